/* File: tc8_consts.vh */
// Constants for the 8-bit timer with two compare units and PWM.
// Included by tc8_tick_gen.v and tc8_timer.v; holds definitions only.
`ifndef TC8_CONSTS_VH
`define TC8_CONSTS_VH

// ----------------------------------------------------------------
// Register byte addresses on the APB
// ----------------------------------------------------------------
`define TC8_ADDR_CTRL_A   8'h00
`define TC8_ADDR_CTRL_B   8'h04
`define TC8_ADDR_COUNT    8'h08
`define TC8_ADDR_CMP_A    8'h0c
`define TC8_ADDR_CMP_B    8'h10
`define TC8_ADDR_FLAGS    8'h14
`define TC8_ADDR_MASK     8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TC8_CA_WGM_LO     1:0
`define TC8_CA_COM_B      5:4
`define TC8_CA_COM_A      7:6
`define TC8_CB_CS         2:0
`define TC8_CB_WGM2       3
`define TC8_CB_FORCE_B    6
`define TC8_CB_FORCE_A    7
`define TC8_FLAG_OVF      0
`define TC8_FLAG_CMP_A    1
`define TC8_FLAG_CMP_B    2

// ----------------------------------------------------------------
// Values and reset values
// ----------------------------------------------------------------
`define TC8_BOTTOM        8'h00
`define TC8_MAX           8'hff
`define TC8_ZERO8         8'h00
`define TC8_ZERO3         3'h0
`define TC8_ZERO2         2'h0
`define TC8_ZERO32        32'h0000_0000

// ----------------------------------------------------------------
// Clock source select codes
// ----------------------------------------------------------------
`define TC8_CS_STOP       3'h0
`define TC8_CS_DIV1       3'h1
`define TC8_CS_DIV8       3'h2
`define TC8_CS_DIV64      3'h3
`define TC8_CS_DIV256     3'h4
`define TC8_CS_DIV1024    3'h5
`define TC8_CS_EXT_FALL   3'h6
`define TC8_CS_EXT_RISE   3'h7

// ----------------------------------------------------------------
// Prescaler tap masks (low bits all ones marks the divided tick)
// ----------------------------------------------------------------
`define TC8_PRE_W         10
`define TC8_TAP_DIV8      10'h007
`define TC8_TAP_DIV64     10'h03f
`define TC8_TAP_DIV256    10'h0ff
`define TC8_TAP_DIV1024   10'h3ff
`define TC8_PRE_ONE       10'h001
`define TC8_PRE_ZERO      10'h000

// ----------------------------------------------------------------
// Waveform modes {wgm2, wgm_lo}
// ----------------------------------------------------------------
`define TC8_WGM_CTC       3'h2
`define TC8_WGM_LO_PHASE  2'h1
`define TC8_WGM_LO_FAST   2'h3

// ----------------------------------------------------------------
// Compare output actions
// ----------------------------------------------------------------
`define TC8_COM_TOGGLE    2'h1
`define TC8_COM_CLEAR     2'h2
`define TC8_COM_SET       2'h3

// Waveform kinds for the output function
`define TC8_KIND_NONPWM   2'h0
`define TC8_KIND_FAST     2'h1
`define TC8_KIND_PHASE    2'h2

`endif

/* File: tc8_tick_gen.v */
// Clock select and prescaler: turns the select code into a one-cycle tick.
// Assumes the external count pin is already synchronous to the clock.
`timescale 1ns/1ps
`include "tc8_consts.vh"

module tc8_tick_gen
#(
  parameter PRE_W = `TC8_PRE_W
)
(
  input  wire       i_clk,
  input  wire       i_arst_n,
  input  wire [2:0] i_cs,        // Clock source select
  input  wire       i_ext_pin,   // External count input
  output reg        o_tick       // Timer tick, one cycle
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [PRE_W-1:0] pre;         // Free running prescaler
  reg             ext_prev;    // Last sample of the count pin
  reg             next_tick;   // Tick for the next cycle

  // Divided tick when the masked low bits are all ones
  function tap;
    input [PRE_W-1:0] cnt;
    input [PRE_W-1:0] msk;
    begin
      tap = ((cnt & msk) == msk);
    end
  endfunction

  // ----------------------------------------------------------------
  // Source and edge selection
  // ----------------------------------------------------------------
  // Chooses the source and the active edge; stop gives no tick
  always @*
  begin
    case (i_cs)
      `TC8_CS_STOP:     next_tick = 1'b0;
      `TC8_CS_DIV1:     next_tick = 1'b1;
      `TC8_CS_DIV8:     next_tick = tap(pre, `TC8_TAP_DIV8);
      `TC8_CS_DIV64:    next_tick = tap(pre, `TC8_TAP_DIV64);
      `TC8_CS_DIV256:   next_tick = tap(pre, `TC8_TAP_DIV256);
      `TC8_CS_DIV1024:  next_tick = tap(pre, `TC8_TAP_DIV1024);
      `TC8_CS_EXT_FALL: next_tick = ext_prev & ~i_ext_pin;
      `TC8_CS_EXT_RISE: next_tick = ~ext_prev & i_ext_pin;
      default:          next_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Prescaler, pin history and tick flop
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pre      <= `TC8_PRE_ZERO;
      ext_prev <= 1'b0;
      o_tick   <= 1'b0;
    end
    else
    begin
      pre      <= pre + `TC8_PRE_ONE;
      ext_prev <= i_ext_pin;
      o_tick   <= next_tick;
    end
  end

endmodule

/* File: tc8_timer.v */
// 8-bit timer with two compare units, waveform outputs and an APB slave.
// Assumes a single 20 MHz clock, inputs synchronous to it, APB master.
`timescale 1ns/1ps
`include "tc8_consts.vh"

module tc8_timer
(
  input  wire        I_REF_CLK,                 // System clock, 20 MHz
  input  wire        I_ARST_N,                  // Async reset, active low
  input  wire        I_PSEL,                    // APB select
  input  wire        I_PENABLE,                 // APB access phase
  input  wire        I_PWRITE,                  // APB direction
  input  wire [7:0]  I_PADDR,                   // APB byte address
  input  wire [31:0] I_PWDATA,                  // APB write data
  input  wire        I_EXTERNAL_COUNT_INPUT,    // External count pin
  input  wire        I_ACK_OVF,                 // Overflow interrupt taken
  input  wire        I_ACK_CMP_A,               // Compare A interrupt taken
  input  wire        I_ACK_CMP_B,               // Compare B interrupt taken
  output reg  [31:0] O_PRDATA,                  // APB read data
  output reg         O_PREADY,                  // APB ready
  output reg         O_PSLVERR,                 // APB error, unmapped
  output reg         O_COMPARE_OUTPUT_A,        // Waveform A
  output reg         O_COMPARE_OUTPUT_B,        // Waveform B
  output reg         O_IRQ_OVF,                 // Masked overflow request
  output reg         O_IRQ_CMP_A,               // Masked compare A request
  output reg         O_IRQ_CMP_B                // Masked compare B request
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [7:0] counter_value;      // Counter                           
  reg        count_down;         // Phase correct direction
  reg  [7:0] compare_value_a;    // Active compare A
  reg  [7:0] compare_value_b;    // Active compare B
  reg  [7:0] cmp_buf_a;          // CPU side buffer A
  reg  [7:0] cmp_buf_b;          // CPU side buffer B
  reg  [2:0] timer_flag_register;
  reg  [2:0] timer_mask_register;
  reg  [1:0] wgm_lo;             // Mode low bits
  reg        wgm2;               // Mode high bit
  reg  [1:0] com_a;              // Output action A
  reg  [1:0] com_b;              // Output action B
  reg  [2:0] clock_source_select;
  reg        match_block;        // Blocks matches after a counter write

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  reg  [7:0] next_counter;
  reg        next_down;
  reg  [7:0] next_cmp_a;
  reg  [7:0] next_cmp_b;
  reg  [7:0] next_buf_a;
  reg  [7:0] next_buf_b;
  reg  [2:0] next_flags;
  reg  [2:0] next_mask;
  reg        next_block;
  reg        next_oc_a;
  reg        next_oc_b;
  reg        ovf_evt;            // Overflow this cycle
  reg        upd_evt;            // Compare buffer transfer this cycle
  reg        bot_evt;            // Fast PWM wraps to bottom
  reg  [2:0] clr_vec;            // Flag clears
  reg  [31:0] next_rdata;
  reg        next_err;

  wire       timer_tick;         // From clock select
  wire [2:0] wgm      = {wgm2, wgm_lo};
  wire       is_pwm   = wgm_lo[0];
  wire       is_phase = (wgm_lo == `TC8_WGM_LO_PHASE);
  wire       is_fast  = (wgm_lo == `TC8_WGM_LO_FAST);
  wire       is_ctc   = (wgm == `TC8_WGM_CTC);
  wire [7:0] top_val  = (wgm2 | is_ctc) ? compare_value_a : `TC8_MAX;
  wire       at_top   = (counter_value == top_val);
  wire       at_bot   = (counter_value == `TC8_BOTTOM);
  wire       at_max   = (counter_value == `TC8_MAX);
  wire [1:0] kind     = is_phase ? `TC8_KIND_PHASE :
                        (is_fast ? `TC8_KIND_FAST : `TC8_KIND_NONPWM);

  // Bus strobes; the write lands at the access edge with ready high
  wire       acc      = I_PSEL & I_PENABLE & O_PREADY;
  wire       wr       = acc & I_PWRITE;
  wire       wr_cnt   = wr & (I_PADDR == `TC8_ADDR_COUNT);
  wire       wr_ca    = wr & (I_PADDR == `TC8_ADDR_CTRL_A);
  wire       wr_cb    = wr & (I_PADDR == `TC8_ADDR_CTRL_B);
  wire       force_a  = wr_cb & I_PWDATA[`TC8_CB_FORCE_A] & ~is_pwm;
  wire       force_b  = wr_cb & I_PWDATA[`TC8_CB_FORCE_B] & ~is_pwm;

  // Continuous comparison, suppressed one tick after a counter write
  wire       match_a  = timer_tick & ~match_block &
                        (counter_value == compare_value_a);
  wire       match_b  = timer_tick & ~match_block &
                        (counter_value == compare_value_b);

  // ----------------------------------------------------------------
  // Waveform output function, shared by both units
  // ----------------------------------------------------------------
  function wave_next;
    input       cur;
    input [1:0] com;
    input [1:0] knd;
    input       hit;
    input       frc;
    input       bot;
    input       down;
    begin
      wave_next = cur;
      case (knd)
        `TC8_KIND_FAST:
        begin
          // Clear or set on match, opposite level at bottom
          if (hit)
            wave_next = (com == `TC8_COM_SET) ? 1'b1 :
                        ((com == `TC8_COM_CLEAR) ? 1'b0 : cur);
          else if (bot)
            wave_next = (com == `TC8_COM_SET) ? 1'b0 :
                        ((com == `TC8_COM_CLEAR) ? 1'b1 : cur);
        end
        `TC8_KIND_PHASE:
        begin
          // Level on match follows the counting direction
          if (hit && com == `TC8_COM_CLEAR)
            wave_next = down;
          else if (hit && com == `TC8_COM_SET)
            wave_next = ~down;
        end
        default:
        begin
          // Non-PWM: toggle, clear or set on match or force
          if (hit || frc)
          begin
            case (com)
              `TC8_COM_TOGGLE: wave_next = ~cur;
              `TC8_COM_CLEAR:  wave_next = 1'b0;
              `TC8_COM_SET:    wave_next = 1'b1;
              default:         wave_next = cur;
            endcase
          end
        end
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Clock select
  // ----------------------------------------------------------------
  tc8_tick_gen u_tick
  (
    .i_clk     (I_REF_CLK),
    .i_arst_n  (I_ARST_N),
    .i_cs      (clock_source_select),
    .i_ext_pin (I_EXTERNAL_COUNT_INPUT),
    .o_tick    (timer_tick)
  );

  // ----------------------------------------------------------------
  // Counter sequence
  // ----------------------------------------------------------------
  // Advances on the tick by mode; a CPU counter write overrides the next count value
  always @*
  begin
    next_counter = counter_value;
    next_down    = count_down;
    ovf_evt      = 1'b0;
    upd_evt      = 1'b0;
    bot_evt      = 1'b0;
    if (timer_tick)
    begin
      if (is_phase)
      begin
        if (!count_down)
        begin
          if (at_top)
          begin
            next_down    = 1'b1;
            next_counter = counter_value - 8'h01;
            upd_evt      = 1'b1;
          end
          else
            next_counter = counter_value + 8'h01;
        end
        else if (at_bot)
        begin
          next_down    = 1'b0;
          next_counter = counter_value + 8'h01;
          ovf_evt      = 1'b1;
        end
        else
          next_counter = counter_value - 8'h01;
      end
      else if (is_fast || is_ctc)
      begin
        if (at_top)
        begin
          next_counter = `TC8_BOTTOM;
          ovf_evt      = is_fast | at_max;
          upd_evt      = is_fast;
          bot_evt      = is_fast;
        end
        else
        begin
          next_counter = counter_value + 8'h01;
          ovf_evt      = at_max;
        end
      end
      else
      begin
        next_counter = counter_value + 8'h01;
        ovf_evt      = at_max;
      end
    end
    if (wr_cnt)
      next_counter = I_PWDATA[7:0];
    next_block = wr_cnt ? 1'b1 : (timer_tick ? 1'b0 : match_block);
  end

  // ----------------------------------------------------------------
  // Compare buffers
  // ----------------------------------------------------------------
  // PWM writes the buffer only; other modes write straight through
  always @*
  begin
    next_buf_a = cmp_buf_a;
    next_buf_b = cmp_buf_b;
    next_cmp_a = compare_value_a;
    next_cmp_b = compare_value_b;
    if (upd_evt && is_pwm)
    begin
      next_cmp_a = cmp_buf_a;
      next_cmp_b = cmp_buf_b;
    end
    if (wr && I_PADDR == `TC8_ADDR_CMP_A)
    begin
      next_buf_a = I_PWDATA[7:0];
      if (!is_pwm)
        next_cmp_a = I_PWDATA[7:0];
    end
    if (wr && I_PADDR == `TC8_ADDR_CMP_B)
    begin
      next_buf_b = I_PWDATA[7:0];
      if (!is_pwm)
        next_cmp_b = I_PWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Flags, mask and waveforms
  // ----------------------------------------------------------------
  // Sets win over clears from write-one or acknowledge
  always @*
  begin
    clr_vec = {I_ACK_CMP_B, I_ACK_CMP_A, I_ACK_OVF};
    if (wr && I_PADDR == `TC8_ADDR_FLAGS)
      clr_vec = clr_vec | I_PWDATA[2:0];
    next_flags = timer_flag_register & ~clr_vec;
    if (ovf_evt)
      next_flags[`TC8_FLAG_OVF] = 1'b1;
    if (match_a)
      next_flags[`TC8_FLAG_CMP_A] = 1'b1;
    if (match_b)
      next_flags[`TC8_FLAG_CMP_B] = 1'b1;
    next_mask = timer_mask_register;
    if (wr && I_PADDR == `TC8_ADDR_MASK)
      next_mask = I_PWDATA[2:0];
    next_oc_a = wave_next(O_COMPARE_OUTPUT_A, com_a, kind, match_a,
                          force_a, bot_evt, count_down);
    next_oc_b = wave_next(O_COMPARE_OUTPUT_B, com_b, kind, match_b,
                          force_b, bot_evt, count_down);
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Read data captured in the setup cycle; unmapped reads give error
  always @*
  begin
    next_rdata = `TC8_ZERO32;
    next_err   = 1'b0;
    case (I_PADDR)
      `TC8_ADDR_CTRL_A: next_rdata[7:0] = {com_a, com_b, 2'h0, wgm_lo};
      `TC8_ADDR_CTRL_B: next_rdata[7:0] = {4'h0, wgm2, clock_source_select};
      `TC8_ADDR_COUNT:  next_rdata[7:0] = counter_value;
      `TC8_ADDR_CMP_A:  next_rdata[7:0] = cmp_buf_a;
      `TC8_ADDR_CMP_B:  next_rdata[7:0] = cmp_buf_b;
      `TC8_ADDR_FLAGS:  next_rdata[2:0] = timer_flag_register;
      `TC8_ADDR_MASK:   next_rdata[2:0] = timer_mask_register;
      default:          next_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // All state and every output flop
  always @(posedge I_REF_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      counter_value       <= `TC8_ZERO8;
      count_down          <= 1'b0;
      compare_value_a     <= `TC8_ZERO8;
      compare_value_b     <= `TC8_ZERO8;
      cmp_buf_a           <= `TC8_ZERO8;
      cmp_buf_b           <= `TC8_ZERO8;
      timer_flag_register <= `TC8_ZERO3;
      timer_mask_register <= `TC8_ZERO3;
      wgm_lo              <= `TC8_ZERO2;
      wgm2                <= 1'b0;
      com_a               <= `TC8_ZERO2;
      com_b               <= `TC8_ZERO2;
      clock_source_select <= `TC8_CS_STOP;
      match_block         <= 1'b0;
      O_PRDATA            <= `TC8_ZERO32;
      O_PREADY            <= 1'b0;
      O_PSLVERR           <= 1'b0;
      O_COMPARE_OUTPUT_A  <= 1'b0;
      O_COMPARE_OUTPUT_B  <= 1'b0;
      O_IRQ_OVF           <= 1'b0;
      O_IRQ_CMP_A         <= 1'b0;
      O_IRQ_CMP_B         <= 1'b0;
    end
    else
    begin
      counter_value       <= next_counter;
      count_down          <= next_down;
      compare_value_a     <= next_cmp_a;
      compare_value_b     <= next_cmp_b;
      cmp_buf_a           <= next_buf_a;
      cmp_buf_b           <= next_buf_b;
      timer_flag_register <= next_flags;
      timer_mask_register <= next_mask;
      match_block         <= next_block;
      if (wr_ca)
      begin
        wgm_lo <= I_PWDATA[`TC8_CA_WGM_LO];
        com_a  <= I_PWDATA[`TC8_CA_COM_A];
        com_b  <= I_PWDATA[`TC8_CA_COM_B];
      end
      if (wr_cb)
      begin
        wgm2                <= I_PWDATA[`TC8_CB_WGM2];
        clock_source_select <= I_PWDATA[`TC8_CB_CS];
      end
      O_PREADY            <= I_PSEL & ~I_PENABLE;
      if (I_PSEL && !I_PENABLE)
      begin
        O_PRDATA  <= next_rdata;
        O_PSLVERR <= next_err;
      end
      O_COMPARE_OUTPUT_A  <= next_oc_a;
      O_COMPARE_OUTPUT_B  <= next_oc_b;
      O_IRQ_OVF   <= timer_flag_register[`TC8_FLAG_OVF] &
                     timer_mask_register[`TC8_FLAG_OVF];
      O_IRQ_CMP_A <= timer_flag_register[`TC8_FLAG_CMP_A] &
                     timer_mask_register[`TC8_FLAG_CMP_A];
      O_IRQ_CMP_B <= timer_flag_register[`TC8_FLAG_CMP_B] &
                     timer_mask_register[`TC8_FLAG_CMP_B];
    end
  end

endmodule

/* File: tc8_chk_assertions.sv */
// Checker for the 8-bit timer: APB answer, read widths, reset and requests.
// Sees only the timer's top ports; bound from the testbench top file.
`timescale 1ns/1ps
`include "tc8_consts.vh"
module tc8_chk (
  input wire logic        I_REF_CLK, I_ARST_N, I_PSEL, I_PENABLE, I_PWRITE, I_ACK_OVF,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA, O_PRDATA,
  input wire logic        O_PREADY, O_PSLVERR, O_COMPARE_OUTPUT_A, O_COMPARE_OUTPUT_B,
  input wire logic        O_IRQ_OVF, O_IRQ_CMP_A, O_IRQ_CMP_B
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);
  // Unmapped address, mapped read, clock select copied from writes
  wire        um  = I_PADDR > `TC8_ADDR_MASK || I_PADDR[1:0] != 2'h0;
  wire        rdy = O_PREADY && !I_PWRITE && !um;
  logic [2:0] cs;
  wire        stp = cs == 3'h0;
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    if (!I_ARST_N) cs <= 3'h0;
    else if (O_PREADY && I_PWRITE && I_PADDR == `TC8_ADDR_CTRL_B) cs <= I_PWDATA[2:0];
  property p_rdy; I_PSEL && !I_PENABLE |=> O_PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_one; O_PREADY |=> !O_PREADY; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err; O_PREADY |-> O_PSLVERR == um; endproperty
  a_err: assert property (p_err) else $error("wrong error response");
  property p_umz; O_PREADY && um && !I_PWRITE |-> O_PRDATA == 32'h0; endproperty
  a_umz: assert property (p_umz) else $error("unmapped read not zero");
  property p_w8; rdy && I_PADDR < `TC8_ADDR_FLAGS |-> O_PRDATA[31:8] == 24'h0; endproperty
  a_w8: assert property (p_w8) else $error("register wider than a byte");
  property p_w3; rdy && I_PADDR >= `TC8_ADDR_FLAGS |-> O_PRDATA[31:3] == 29'h0; endproperty
  a_w3: assert property (p_w3) else $error("flag or mask wider than three bits");
  property p_rst; !$past(I_ARST_N) |-> !(O_PREADY || O_IRQ_OVF || O_IRQ_CMP_A || O_COMPARE_OUTPUT_A); endproperty
  a_rst: assert property (p_rst) else $error("output high after reset");
  property p_ack; stp && $past(stp, 3) && I_ACK_OVF |=> ##1 !O_IRQ_OVF; endproperty
  a_ack: assert property (p_ack) else $error("request kept after acknowledge");
  c_err: cover property (O_PREADY && O_PSLVERR);
  c_cmp: cover property ($rose(O_IRQ_CMP_A));
  c_ovf: cover property ($rose(O_IRQ_OVF));
endmodule

/* File: test_tc8_timer.sv */
// Self-checking testbench for the 8-bit timer, driven over APB.
// Assumes the timer top and its constants header are compiled first.
`timescale 1ns/1ps
`include "tc8_consts.vh"
module test_tc8_timer;
  logic        I_REF_CLK = 0, I_ARST_N = 0, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0;
  logic        I_EXTERNAL_COUNT_INPUT = 0, I_ACK_OVF = 0, I_ACK_CMP_A = 0, I_ACK_CMP_B = 0;
  logic [7:0]  I_PADDR = 0;
  logic [31:0] I_PWDATA = 0, O_PRDATA, rd;
  logic        O_PREADY, O_PSLVERR, O_COMPARE_OUTPUT_A, O_COMPARE_OUTPUT_B, er;
  logic        O_IRQ_OVF, O_IRQ_CMP_A, O_IRQ_CMP_B;
  int          n_fail = 0, n_checks = 0;
  tc8_timer tc8_timer_i (.I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .I_EXTERNAL_COUNT_INPUT(I_EXTERNAL_COUNT_INPUT), .I_ACK_OVF(I_ACK_OVF), .I_ACK_CMP_A(I_ACK_CMP_A),
    .I_ACK_CMP_B(I_ACK_CMP_B), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_COMPARE_OUTPUT_A(O_COMPARE_OUTPUT_A), .O_COMPARE_OUTPUT_B(O_COMPARE_OUTPUT_B),
    .O_IRQ_OVF(O_IRQ_OVF), .O_IRQ_CMP_A(O_IRQ_CMP_A), .O_IRQ_CMP_B(O_IRQ_CMP_B));
  initial forever #25 I_REF_CLK = ~I_REF_CLK;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge I_REF_CLK);
  endtask
  // One APB transfer; request held until ready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge I_REF_CLK);
    I_PSEL <= 1'b1; I_PWRITE <= w; I_PADDR <= a; I_PWDATA <= d;
    @(posedge I_REF_CLK);
    I_PENABLE <= 1'b1;
    do @(posedge I_REF_CLK); while (O_PREADY !== 1'b1);
    rd = O_PRDATA; er = O_PSLVERR;
    I_PSEL <= 1'b0; I_PENABLE <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rdc(string n, logic [7:0] a, logic [31:0] e); apb(1'b0, a, 0); chk(n, rd, e); endtask
  task automatic t_regs;
    for (int a = 0; a <= 24; a += 4) rdc("reset value", 8'(a), 0);
    chk("outputs", {O_IRQ_OVF, O_IRQ_CMP_A, O_IRQ_CMP_B, O_COMPARE_OUTPUT_A, O_COMPARE_OUTPUT_B}, 0);
    wr(`TC8_ADDR_CMP_B, 32'h1ab);
    rdc("compare b", `TC8_ADDR_CMP_B, 32'hab);
    wr(8'h1c, 32'hff);
    chk("unmapped write", er, 1);
    rdc("unmapped read", 8'h1c, 0);
    wr(`TC8_ADDR_COUNT, 32'h37);
    cyc(20);
    rdc("stopped counter", `TC8_ADDR_COUNT, 32'h37);
    $display("register and stop test done");
  endtask
  // Compare match flag, mask gating, clear by writing one
  task automatic t_cmp;
    wr(`TC8_ADDR_MASK, 2); wr(`TC8_ADDR_CMP_A, 10); wr(`TC8_ADDR_COUNT, 0);
    wr(`TC8_ADDR_CTRL_B, `TC8_CS_DIV1);
    for (int i = 0; i < 40 && O_IRQ_CMP_A !== 1'b1; i++) cyc(1);
    wr(`TC8_ADDR_CTRL_B, `TC8_CS_STOP);
    chk("compare a request", O_IRQ_CMP_A, 1);
    rdc("compare a flag", `TC8_ADDR_FLAGS, 2);
    wr(`TC8_ADDR_MASK, 0); cyc(2);
    chk("masked request", O_IRQ_CMP_A, 0);
    wr(`TC8_ADDR_MASK, 2); wr(`TC8_ADDR_FLAGS, 2); cyc(2);
    chk("cleared request", O_IRQ_CMP_A, 0);
    rdc("cleared flag", `TC8_ADDR_FLAGS, 0);
    $display("compare test done");
  endtask
  // Wrap from all ones, then acknowledge the request
  task automatic t_ovf;
    wr(`TC8_ADDR_MASK, 1); wr(`TC8_ADDR_COUNT, 32'hfe); wr(`TC8_ADDR_CTRL_B, `TC8_CS_DIV1);
    for (int i = 0; i < 20 && O_IRQ_OVF !== 1'b1; i++) cyc(1);
    wr(`TC8_ADDR_CTRL_B, `TC8_CS_STOP);
    chk("overflow request", O_IRQ_OVF, 1);
    apb(1'b0, `TC8_ADDR_COUNT, 0);
    chk("counter wrapped", rd < 16, 1);
    @(posedge I_REF_CLK) I_ACK_OVF <= 1'b1;
    @(posedge I_REF_CLK) I_ACK_OVF <= 1'b0;
    cyc(2);
    chk("acknowledged request", O_IRQ_OVF, 0);
    $display("overflow test done");
  endtask
  task automatic t_ctc;
    wr(`TC8_ADDR_CTRL_A, 2); wr(`TC8_ADDR_CMP_A, 5); wr(`TC8_ADDR_COUNT, 0);
    wr(`TC8_ADDR_CTRL_B, `TC8_CS_DIV1);
    for (int i = 0; i < 12; i++)
    begin
      apb(1'b0, `TC8_ADDR_COUNT, 0);
      chk("clear on match", rd <= 5, 1);
    end
    wr(`TC8_ADDR_CTRL_B, `TC8_CS_STOP); wr(`TC8_ADDR_CTRL_A, 0);
    $display("clear on match test done");
  endtask
  // Three pulses and a final rise: four rising or three falling edges
  task automatic t_ext;
    for (int k = 0; k < 2; k++)
    begin
      wr(`TC8_ADDR_COUNT, 0);
      wr(`TC8_ADDR_CTRL_B, k ? `TC8_CS_EXT_FALL : `TC8_CS_EXT_RISE);
      repeat (3)
      begin
        @(posedge I_REF_CLK) I_EXTERNAL_COUNT_INPUT <= 1'b1;
        cyc(3);
        @(posedge I_REF_CLK) I_EXTERNAL_COUNT_INPUT <= 1'b0;
        cyc(3);
      end
      @(posedge I_REF_CLK) I_EXTERNAL_COUNT_INPUT <= 1'b1;
      cyc(4);
      wr(`TC8_ADDR_CTRL_B, `TC8_CS_STOP);
      rdc("external edges", `TC8_ADDR_COUNT, k ? 3 : 4);
    end
    $display("external clock test done");
  endtask
  task automatic t_force;
    wr(`TC8_ADDR_CTRL_A, 32'h50);
    for (int k = 1; k >= 0; k--)
    begin
      wr(`TC8_ADDR_CTRL_B, 32'hc0); cyc(2);
      chk("forced outputs", {O_COMPARE_OUTPUT_A, O_COMPARE_OUTPUT_B}, {2{k[0]}});
    end
    $display("force test done");
  endtask
  // Fast waveform: a buffered compare takes effect only at the wrap
  task automatic t_pwm;
    wr(`TC8_ADDR_MASK, 4);
    wr(`TC8_ADDR_FLAGS, 7);
    wr(`TC8_ADDR_CTRL_A, 32'h83);
    wr(`TC8_ADDR_COUNT, 32'h10);
    wr(`TC8_ADDR_CMP_A, 32'h20);
    wr(`TC8_ADDR_CTRL_B, `TC8_CS_DIV1);
    cyc(30);
    rdc("no match before wrap", `TC8_ADDR_FLAGS, 0);
    for (int i = 0; i < 300 && O_COMPARE_OUTPUT_A !== 1'b1; i++) cyc(1);
    chk("set at bottom", O_COMPARE_OUTPUT_A, 1);
    for (int i = 0; i < 60 && O_COMPARE_OUTPUT_A !== 1'b0; i++) cyc(1);
    chk("cleared on match", O_COMPARE_OUTPUT_A, 0);
    wr(`TC8_ADDR_CTRL_B, `TC8_CS_STOP);
    rdc("wrap and match flags", `TC8_ADDR_FLAGS, 7);
    chk("compare b request", O_IRQ_CMP_B, 1);
    $display("pwm test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial
  begin
    cyc(3);
    I_ARST_N <= 1'b1;
    t_regs; t_cmp; t_ovf; t_ctc; t_ext; t_force; t_pwm;
    stop_test;
  end
  initial
  begin
    cyc(5000);
    n_fail++;
    stop_test;
  end
endmodule
bind tc8_timer tc8_chk tc8_chk_i (.I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_ACK_OVF(I_ACK_OVF), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_COMPARE_OUTPUT_A(O_COMPARE_OUTPUT_A), .O_COMPARE_OUTPUT_B(O_COMPARE_OUTPUT_B),
  .O_IRQ_OVF(O_IRQ_OVF), .O_IRQ_CMP_A(O_IRQ_CMP_A), .O_IRQ_CMP_B(O_IRQ_CMP_B));
